// ===== lcdid_decoder.sv
// Instruction decoder and display control state for the LCD driver.
`timescale 1ns/1ps
module lcdid_decoder
   import lcdid_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic serial_mode,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic cmd_data_select,
   input wire logic in_read,
   input wire logic [7:0] in_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   input wire logic pix_valid,
   input wire logic [3:0] pix_page,
   input wire logic [7:0] pix_col,
   output logic [7:0] pix_out,
   output logic display_on,
   output logic inverse,
   output logic whole_on,
   output logic power_save,
   output logic sub_table,
   output logic adc_reverse,
   output logic drive_on,
   output logic [6:0] start_line,
   output logic [3:0] page_addr,
   output logic [7:0] col_addr,
   output logic [3:0] b1_start,
   output logic [3:0] b1_count,
   output logic [3:0] b2_start,
   output logic [3:0] b2_count,
   output logic b2_enable,
   output logic [6:0] duty_lines,
   output logic [5:0] inv_lines,
   output logic [7:0] contrast_level,
   output logic [2:0] bias_sel,
   output logic [1:0] boost_sel
);
   lcdid_table_t table_sel;
   logic [7:0] b0_data;
   logic [7:0] b1_data;
   logic b0_full;
   logic b1_full;
   logic [3:0] pend_b1_start;
   logic [3:0] pend_b1_count;
   logic [3:0] pend_b2_start;
   logic [3:0] pend_b2_count;
   logic [1:0] inv_hi;
   logic [3:0] inv_lo;
   logic [3:0] con_hi;
   logic [3:0] con_lo;
   logic [2:0] start_hi;
   logic mem_rd_en;
   logic [7:0] mem_rd_data;
   logic rd_pending;
   logic pix_pending;
   logic [7:0] pix_mem;
   logic [2:0] next_fill;
   logic next_rd_data_take;
   logic take;
   logic data_wr;
   logic data_rd;
   logic is_cmd;
   logic [4:0] units_total;

   // Pages are packed at the panel width so that all fifteen pages fit.
   function automatic logic [10:0] mem_addr(input logic [3:0] pg,
                                            input logic [7:0] col);
      mem_addr = 11'(pg) * 11'(LCDID_COLS) + {3'h0, col};
   endfunction

   function automatic logic [7:0] col_step(input logic [7:0] col);
      col_step = (col == LCDID_COL_LAST) ? col : 8'(col + 8'h01);
   endfunction

   // A read is taken only when the two-entry output buffer has room for it.
   assign take = in_valid && in_ready;
   assign is_cmd = take && !cmd_data_select && !in_read;
   assign data_wr = take && cmd_data_select && !in_read;
   assign data_rd = take && cmd_data_select && in_read && !serial_mode;
   assign next_rd_data_take = rd_valid && rd_ready;
   assign mem_rd_en = data_rd || pix_valid;
   // Ready is registered, so it counts the entries held after this edge,
   // a read in flight included, and leaves room for one more.
   assign next_fill = {2'b00, b0_full} + {2'b00, b1_full} +
                      {2'b00, rd_pending} + {2'b00, data_rd} -
                      {2'b00, next_rd_data_take};

   always_ff @(posedge mclk) begin
      if (srst) begin
         in_ready <= 1'b0;
      end else begin
         in_ready <= (next_fill <= 3'h1);
      end
   end

   lcdid_mem u_mem (
      .mclk(mclk),
      .wr_en(data_wr),
      .wr_addr(mem_addr(page_addr, col_addr)),
      .wr_data(in_data),
      .rd_en(mem_rd_en),
      .rd_addr(data_rd ? mem_addr(page_addr, col_addr)
                       : mem_addr(pix_page, pix_col)),
      .rd_data(mem_rd_data)
   );

   // Pixel port yields to host reads; a held request is retried.
   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_pending <= 1'b0;
         pix_pending <= 1'b0;
      end else begin
         rd_pending <= data_rd;
         pix_pending <= pix_valid && !data_rd;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pix_mem <= 8'h00;
      end else if (pix_pending) begin
         pix_mem <= mem_rd_data;
      end
   end

   // Whole-on wins over polarity; memory is never touched here.
   always_ff @(posedge mclk) begin
      if (srst) begin
         pix_out <= 8'h00;
      end else if (!display_on || power_save) begin
         pix_out <= 8'h00;
      end else if (whole_on) begin
         pix_out <= 8'hFF;
      end else begin
         pix_out <= inverse ? ~pix_mem : pix_mem;
      end
   end

   // Two-entry read buffer: a stalled receiver loses no byte.
   always_ff @(posedge mclk) begin
      if (srst) begin
         b0_full <= 1'b0;
         b1_full <= 1'b0;
         b0_data <= 8'h00;
         b1_data <= 8'h00;
      end else begin
         if (next_rd_data_take) begin
            if (b1_full) begin
               b0_data <= b1_data;
               b1_full <= 1'b0;
               if (rd_pending) begin
                  b1_data <= mem_rd_data;
                  b1_full <= 1'b1;
               end
            end else if (rd_pending) begin
               b0_data <= mem_rd_data;
            end else begin
               b0_full <= 1'b0;
            end
         end else if (rd_pending) begin
            if (!b0_full) begin
               b0_data <= mem_rd_data;
               b0_full <= 1'b1;
            end else begin
               b1_data <= mem_rd_data;
               b1_full <= 1'b1;
            end
         end
      end
   end

   always_comb begin
      rd_valid = b0_full;
      rd_data = b0_data;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         col_addr <= 8'h00;
         page_addr <= 4'h0;
      end else if (data_wr || data_rd) begin
         col_addr <= col_step(col_addr);
      end else if (is_cmd && table_sel == LCDID_TABLE_MAIN) begin
         if (in_data[7:4] == LCDID_OP_COL_HI) begin
            col_addr <= {in_data[3:0], col_addr[3:0]};
         end else if (in_data[7:4] == LCDID_OP_COL_LO) begin
            col_addr <= {col_addr[7:4], in_data[3:0]};
         end else if (in_data[7:4] == LCDID_OP_PAGE) begin
            page_addr <= in_data[3:0];
         end
      end
   end

   // One flag picks the decode table.
   always_ff @(posedge mclk) begin
      if (srst) begin
         table_sel <= LCDID_TABLE_MAIN;
      end else if (is_cmd) begin
         if (table_sel == LCDID_TABLE_MAIN &&
             in_data == LCDID_OP_SUB_ENTER) begin
            table_sel <= LCDID_TABLE_SUB;
         end else if (table_sel == LCDID_TABLE_SUB &&
                      in_data == LCDID_SUB_EXIT) begin
            table_sel <= LCDID_TABLE_MAIN;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         sub_table <= 1'b0;
      end else begin
         sub_table <= (table_sel == LCDID_TABLE_SUB);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         display_on <= 1'b0;
         inverse <= 1'b0;
         whole_on <= 1'b0;
         adc_reverse <= 1'b0;
         drive_on <= 1'b0;
         start_line <= 7'h00;
         start_hi <= 3'h0;
         bias_sel <= LCDID_BIAS_RESET;
         boost_sel <= LCDID_BOOST_RESET;
      end else if (is_cmd && table_sel == LCDID_TABLE_MAIN) begin
         if (in_data[7:1] == LCDID_OP_DISP_ONOFF) begin
            display_on <= in_data[0];
         end else if (in_data[7:1] == LCDID_OP_INVERSE) begin
            inverse <= in_data[0];
         end else if (in_data[7:1] == LCDID_OP_WHOLE) begin
            whole_on <= in_data[0];
         end else if (in_data[7:1] == LCDID_OP_ADC) begin
            adc_reverse <= in_data[0];
         end else if (in_data[7:1] == LCDID_OP_DRIVE) begin
            drive_on <= in_data[0];
         end else if (in_data[7:4] == LCDID_OP_BIAS) begin
            bias_sel <= in_data[2:0];
         end else if (in_data[7:2] == LCDID_OP_BOOST) begin
            boost_sel <= in_data[1:0];
         end else if (in_data[7:4] == LCDID_OP_START_HI) begin
            start_hi <= in_data[2:0];
         end else if (in_data[7:4] == LCDID_OP_START_LO) begin
            start_line <= {start_hi, in_data[3:0]};
         end
      end
   end

   // Power-save follows whole-on while the display is off.
   always_ff @(posedge mclk) begin
      if (srst) begin
         power_save <= 1'b0;
      end else begin
         power_save <= whole_on && !display_on;
      end
   end

   // Partial display settings are staged, then applied together.
   always_ff @(posedge mclk) begin
      if (srst) begin
         pend_b1_start <= 4'h0;
         pend_b1_count <= LCDID_UNITS_ALL;
         pend_b2_start <= 4'h0;
         pend_b2_count <= 4'h0;
      end else if (is_cmd && table_sel == LCDID_TABLE_SUB) begin
         case (in_data[7:4])
            LCDID_SUB_B1_START: pend_b1_start <= in_data[3:0];
            LCDID_SUB_B1_COUNT: pend_b1_count <= in_data[3:0];
            LCDID_SUB_B2_START: pend_b2_start <= in_data[3:0];
            LCDID_SUB_B2_COUNT: pend_b2_count <= in_data[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         b1_start <= 4'h0;
         b1_count <= LCDID_UNITS_ALL;
         b2_start <= 4'h0;
         b2_count <= 4'h0;
         b2_enable <= 1'b0;
      end else if (is_cmd && table_sel == LCDID_TABLE_SUB &&
                   in_data == LCDID_SUB_PARTIAL_ON) begin
         b1_start <= pend_b1_start;
         b1_count <= pend_b1_count;
         b2_start <= pend_b2_start;
         b2_count <= pend_b2_count;
         if (pend_b1_start == 4'h0 && pend_b1_count == LCDID_UNITS_ALL) begin
            b2_enable <= 1'b0;
         end else begin
            b2_enable <= !(pend_b2_start == 4'h0 &&
                           pend_b2_count == 4'h0);
         end
      end
   end

   // Displayed units are packed from page zero, so only the total matters.
   assign units_total = b2_enable ? 5'(b1_count + b2_count)
                                  : {1'b0, b1_count};

   always_ff @(posedge mclk) begin
      if (srst) begin
         duty_lines <= LCDID_DUTY_RESET;
      end else begin
         duty_lines <= 7'(units_total * LCDID_COMMONS_PER_UNIT);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         inv_hi <= 2'h0;
         inv_lo <= 4'h0;
         inv_lines <= 6'h00;
      end else if (is_cmd && table_sel == LCDID_TABLE_SUB) begin
         if (in_data[7:4] == LCDID_SUB_INV_HI) begin
            inv_hi <= in_data[1:0];
         end else if (in_data[7:4] == LCDID_SUB_INV_LO) begin
            inv_lo <= in_data[3:0];
         end else if (in_data == LCDID_SUB_INV_EXEC) begin
            inv_lines <= {inv_hi, inv_lo};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         con_hi <= 4'hF;
         con_lo <= 4'hF;
         contrast_level <= LCDID_CONTRAST_RESET;
      end else if (is_cmd && table_sel == LCDID_TABLE_SUB) begin
         if (in_data[7:4] == LCDID_SUB_CON_HI) begin
            con_hi <= in_data[3:0];
         end else if (in_data[7:4] == LCDID_SUB_CON_LO) begin
            con_lo <= in_data[3:0];
         end else if (in_data == LCDID_SUB_CON_EXEC) begin
            contrast_level <= {con_hi, con_lo};
         end
      end
   end
endmodule // lcdid_decoder

// ===== lcdid_pkg.sv
// Constants and types for the LCD instruction decoder.
package lcdid_pkg;
   localparam int LCDID_COLS = 132;
   localparam int LCDID_PAGES = 15;
   localparam int LCDID_DEPTH = 2048;
   localparam logic [7:0] LCDID_COL_LAST = 8'h83;
   localparam logic [3:0] LCDID_UNITS_ALL = 4'hB;
   localparam logic [3:0] LCDID_UNIT_MAX = 4'hA;
   localparam logic [7:0] LCDID_COMMONS_PER_UNIT = 8'h08;
   localparam logic [7:0] LCDID_CONTRAST_RESET = 8'hFF;
   localparam logic [2:0] LCDID_BIAS_RESET = 3'h6;
   localparam logic [1:0] LCDID_BOOST_RESET = 2'h3;
   localparam logic [6:0] LCDID_DUTY_RESET = 7'h58;
   // Main table opcodes (full byte or upper bits).
   localparam logic [6:0] LCDID_OP_DISP_ONOFF = 7'h57;
   localparam logic [3:0] LCDID_OP_START_HI = 4'h5;
   localparam logic [3:0] LCDID_OP_START_LO = 4'h6;
   localparam logic [3:0] LCDID_OP_PAGE = 4'hC;
   localparam logic [3:0] LCDID_OP_COL_HI = 4'h1;
   localparam logic [3:0] LCDID_OP_COL_LO = 4'h0;
   localparam logic [6:0] LCDID_OP_INVERSE = 7'h53;
   localparam logic [6:0] LCDID_OP_WHOLE = 7'h52;
   localparam logic [7:0] LCDID_OP_SUB_ENTER = 8'h70;
   localparam logic [3:0] LCDID_OP_BIAS = 4'hB;
   localparam logic [5:0] LCDID_OP_BOOST = 6'h0C;
   localparam logic [6:0] LCDID_OP_DRIVE = 7'h11;
   localparam logic [6:0] LCDID_OP_ADC = 7'h50;
   // Sub table opcodes.
   localparam logic [3:0] LCDID_SUB_B1_START = 4'h0;
   localparam logic [3:0] LCDID_SUB_B1_COUNT = 4'h1;
   localparam logic [3:0] LCDID_SUB_B2_START = 4'h2;
   localparam logic [3:0] LCDID_SUB_B2_COUNT = 4'h3;
   localparam logic [7:0] LCDID_SUB_PARTIAL_ON = 8'h40;
   localparam logic [3:0] LCDID_SUB_INV_HI = 4'h5;
   localparam logic [3:0] LCDID_SUB_INV_LO = 4'h6;
   localparam logic [7:0] LCDID_SUB_INV_EXEC = 8'h70;
   localparam logic [3:0] LCDID_SUB_CON_HI = 4'h8;
   localparam logic [3:0] LCDID_SUB_CON_LO = 4'h9;
   localparam logic [7:0] LCDID_SUB_CON_EXEC = 8'hA0;
   localparam logic [7:0] LCDID_SUB_EXIT = 8'h71;
   typedef enum logic {LCDID_TABLE_MAIN, LCDID_TABLE_SUB} lcdid_table_t;
endpackage

// ===== lcdid_mem.sv
// Display memory with registered read data.
`timescale 1ns/1ps
module lcdid_mem
   import lcdid_pkg::*;
(
   input wire logic mclk,
   input wire logic wr_en,
   input wire logic [10:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   input wire logic [10:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:LCDID_DEPTH-1];

   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // lcdid_mem

// ===== lcdid_checker_sva.sv
// Port checks for the LCD instruction decoder.
`timescale 1ns/1ps
module lcdid_checker
   import lcdid_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic serial_mode,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic cmd_data_select,
   input wire logic in_read,
   input wire logic [7:0] in_data,
   input wire logic rd_valid,
   input wire logic pix_valid,
   input wire logic [7:0] pix_out,
   input wire logic display_on,
   input wire logic whole_on,
   input wire logic power_save,
   input wire logic sub_table,
   input wire logic [7:0] col_addr,
   input wire logic [6:0] duty_lines,
   input wire logic [5:0] inv_lines,
   input wire logic [7:0] contrast_level
);
   logic tk;
   logic wt;
   logic rt;
   assign tk = in_valid && in_ready && !cmd_data_select && !in_read;
   assign wt = in_valid && in_ready && cmd_data_select && !in_read;
   assign rt = in_valid && in_ready && cmd_data_select && in_read;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   AST_WR_INC: assert property (wt && col_addr < LCDID_COL_LAST
      |=> col_addr == $past(col_addr) + 8'h01) else $error("write no inc");
   AST_RD_INC: assert property (rt && !serial_mode && col_addr < 8'h83
      |=> col_addr == $past(col_addr) + 8'h01) else $error("read no inc");
   AST_RD_ANS: assert property (rt && !serial_mode && !rd_valid
      |-> ##2 rd_valid) else $error("read not answered");
   AST_RD_SER: assert property (rt && serial_mode && !rd_valid
      |=> $stable(col_addr) ##1 !rd_valid) else $error("serial read");
   AST_WHOLE: assert property ((whole_on && display_on && pix_valid)[*4]
      |-> pix_out == 8'hFF) else $error("whole display not lit");
   AST_PSAVE: assert property ((whole_on && !display_on)[*2]
      |-> power_save && pix_out == 8'h00) else $error("no power save");
   AST_SUB_IN: assert property (tk && in_data == 8'h70 && !sub_table
      |-> ##2 sub_table) else $error("sub table not entered");
   AST_SUB_OUT: assert property (tk && in_data == 8'h71 && sub_table
      |-> ##2 !sub_table) else $error("sub table not left");
   AST_DUTY: assert property (duty_lines <= 7'h58
      && duty_lines[2:0] == 3'h0) else $error("duty not units of eight");
   AST_INV: assert property ($changed(inv_lines) |-> $past(tk
      && in_data == 8'h70) || $past(tk && in_data == 8'h70, 2))
      else $error("inverse count moved early");
   AST_CON: assert property ($changed(contrast_level) |-> $past(tk
      && in_data == 8'hA0) || $past(tk && in_data == 8'hA0, 2))
      else $error("contrast moved early");
   cover property (rt && !serial_mode);
   cover property ($rose(sub_table));
   cover property ($rose(power_save));
endmodule // lcdid_checker
bind lcdid_decoder lcdid_checker lcdid_checker_i (.mclk, .srst, .serial_mode,
   .in_valid, .in_ready, .cmd_data_select, .in_read, .in_data, .rd_valid,
   .pix_valid, .pix_out, .display_on, .whole_on, .power_save, .sub_table,
   .col_addr, .duty_lines, .inv_lines, .contrast_level);

// ===== lcdid_host.sv
// Host model that offers queued transfers and may stall read data.
`timescale 1ns/1ps
module lcdid_host (
   input wire logic mclk,
   input wire logic srst,
   input wire logic in_ready,
   output logic in_valid,
   output logic cmd_data_select,
   output logic in_read,
   output logic [7:0] in_data,
   output logic rd_ready
);
   logic [9:0] q[$];
   logic slow = 1'b0;
   task push(input logic [9:0] r);
      q.push_back(r);
   endtask
   // A request is held until taken; an idle bus shows changing data.
   always @(posedge mclk) begin
      rd_ready <= slow ? 1'($urandom) : 1'b1;
      if (srst) begin
         in_valid <= 1'b0;
         cmd_data_select <= 1'b0;
         in_read <= 1'b0;
         in_data <= 8'h00;
      end else if (!in_valid || in_ready) begin
         if (q.size() != 0) begin
            in_valid <= 1'b1;
            {cmd_data_select, in_read, in_data} <= q.pop_front();
         end else begin
            in_valid <= 1'b0;
            in_data <= ~in_data;
         end
      end
   end
endmodule // lcdid_host

// ===== test_lcd_instruction_decoder.sv
// Self-checking bench for the LCD instruction decoder.
`timescale 1ns/1ps
module test_lcd_instruction_decoder;
   import lcdid_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic serial_mode = 1'b0;
   logic pix_valid = 1'b0;
   logic [3:0] pix_page = 4'h0;
   logic [7:0] pix_col = 8'h00;
   logic in_valid, in_ready, cmd_data_select, in_read, rd_valid, rd_ready;
   logic display_on, inverse, whole_on, power_save, sub_table;
   logic adc_reverse, drive_on, b2_enable;
   logic [7:0] in_data, rd_data, pix_out, col_addr, contrast_level, v;
   logic [6:0] start_line, duty_lines;
   logic [3:0] page_addr, b1_start, b1_count, b2_start, b2_count;
   logic [5:0] inv_lines;
   logic [2:0] bias_sel;
   logic [1:0] boost_sel;
   int n_mismatch = 0;
   int comparisons = 0;
   int col = 0;
   int page = 0;
   logic [7:0] mem[int];
   int expq[$];
   always #50 mclk = ~mclk;
   lcdid_decoder lcdid_decoder_i (.mclk, .srst, .serial_mode, .in_valid,
      .in_ready, .cmd_data_select, .in_read, .in_data, .rd_valid, .rd_ready,
      .rd_data, .pix_valid, .pix_page, .pix_col, .pix_out, .display_on,
      .inverse, .whole_on, .power_save, .sub_table, .adc_reverse, .drive_on,
      .start_line, .page_addr, .col_addr, .b1_start, .b1_count, .b2_start,
      .b2_count, .b2_enable, .duty_lines, .inv_lines, .contrast_level,
      .bias_sel, .boost_sel);
   lcdid_host lcdid_host_i (.mclk, .srst, .in_ready, .in_valid,
      .cmd_data_select, .in_read, .in_data, .rd_ready);
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task tally_and_finish;
      if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task cmd(input logic [7:0] b);
      lcdid_host_i.push({2'b00, b});
   endtask
   task wr(input logic [7:0] d);
      lcdid_host_i.push({2'b10, d});
      mem[page * 256 + col] = d;
      if (col < 131) col++;
   endtask
   // A dummy read is expected but its byte is not compared.
   task rd(input bit dc);
      lcdid_host_i.push({2'b11, 8'h00});
      if (!serial_mode) begin
         expq.push_back(dc ? -1 : int'(mem[page * 256 + col]));
         if (col < 131) col++;
      end
   endtask
   task setcol(input logic [7:0] c);
      cmd({4'h1, c[7:4]});
      cmd({4'h0, c[3:0]});
      col = c;
   endtask
   task setpage(input logic [3:0] p);
      cmd({4'hC, p});
      page = p;
   endtask
   task sync;
      int k;
      k = 0;
      while ((lcdid_host_i.q.size() != 0 || in_valid) && k < 500) begin
         @(posedge mclk);
         k++;
      end
      repeat (6) @(posedge mclk);
   endtask
   task part(input logic [3:0] s1, c1, s2, c2, input logic [7:0] dt,
      input logic e);
      cmd({4'h0, s1});
      cmd({4'h1, c1});
      cmd({4'h2, s2});
      cmd({4'h3, c2});
      cmd(LCDID_SUB_PARTIAL_ON);
      sync;
      chk("duty", 8'(duty_lines), dt);
      chk("b2_enable", 8'(b2_enable), 8'(e));
      chk("b1_count", 8'(b1_count), 8'(c1));
      chk("starts", {b1_start, b2_start}, {s1, s2});
   endtask
   always @(posedge mclk) begin
      if (rd_valid === 1'b1 && rd_ready) begin
         if (expq.size() == 0) chk("rd_extra", 8'h01, 8'h00);
         else if (expq[0] < 0) void'(expq.pop_front());
         else chk("rd_data", rd_data, 8'(expq.pop_front()));
      end
   end
   initial begin
      #2000000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'h13294795));
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("duty_rst", 8'(duty_lines), 8'h58);
      chk("con_rst", contrast_level, 8'hFF);
      chk("sub_rst", 8'(sub_table), 8'h00);
      lcdid_host_i.slow = 1'b1;
      setpage(4'h3);
      setcol(8'h7E);
      for (int i = 0; i < 8; i++) wr(8'($urandom));
      setcol(8'h7E);
      rd(1'b1);
      for (int i = 0; i < 8; i++) rd(1'b0);
      sync;
      chk("col_sat", col_addr, 8'h83);
      chk("page", 8'(page_addr), 8'h03);
      serial_mode <= 1'b1;
      sync;
      setcol(8'h10);
      rd(1'b0);
      sync;
      chk("col_ser", col_addr, 8'h10);
      serial_mode <= 1'b0;
      setpage(4'h1);
      setcol(8'h05);
      v = 8'($urandom);
      wr(v);
      pix_page <= 4'h1;
      pix_col <= 8'h05;
      pix_valid <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         cmd({7'h57, m[0]});
         cmd({7'h53, m[1]});
         cmd({7'h52, m[2]});
         sync;
         chk("pix", pix_out, !m[0] ? 8'h00 : m[2] ? 8'hFF
             : v ^ {8{m[1]}});
         chk("mode", 8'({whole_on, inverse, display_on}), 8'(m));
         chk("psave", 8'(power_save), 8'(m[2] & !m[0]));
      end
      cmd(8'hA4);
      cmd(8'hA6);
      setcol(8'h04);
      rd(1'b1);
      rd(1'b0);
      cmd(8'h22);
      cmd(LCDID_OP_SUB_ENTER);
      sync;
      chk("sub_in", 8'(sub_table), 8'h01);
      part(4'h0, 4'h2, 4'h4, 4'h5, 8'h38, 1'b1);
      part(4'h0, 4'hB, 4'h4, 4'h5, 8'h58, 1'b0);
      part(4'h3, 4'h4, 4'h0, 4'h0, 8'h20, 1'b0);
      cmd(8'h53);
      cmd(8'h6A);
      cmd(8'h83);
      cmd(8'h97);
      sync;
      chk("inv_hold", 8'(inv_lines), 8'h00);
      chk("con_hold", contrast_level, 8'hFF);
      cmd(LCDID_SUB_INV_EXEC);
      cmd(LCDID_SUB_CON_EXEC);
      sync;
      chk("inv", 8'(inv_lines), 8'h3A);
      chk("con", contrast_level, 8'h37);
      cmd(LCDID_SUB_EXIT);
      cmd(8'h81);
      cmd(8'h90);
      cmd(8'hA0);
      sync;
      chk("sub_out", 8'(sub_table), 8'h00);
      chk("con_main", contrast_level, 8'h37);
      for (int i = 0; i < 8; i++) begin
         cmd({4'hB, 1'($urandom), i[2:0]});
         sync;
         chk("bias", 8'(bias_sel >> (i >= 6)), 8'(i >> (i >= 6)));
      end
      for (int i = 0; i < 4; i++) begin
         cmd({6'h0C, i[1:0]});
         sync;
         chk("boost", 8'(boost_sel), 8'(i));
      end
      cmd(8'hA1);
      cmd(8'h23);
      cmd(8'h53);
      cmd(8'h67);
      cmd(LCDID_OP_SUB_ENTER);
      cmd(8'h8F);
      cmd(8'h9F);
      cmd(LCDID_SUB_CON_EXEC);
      cmd(LCDID_SUB_EXIT);
      sync;
      chk("ctl", 8'({adc_reverse, drive_on}), 8'h03);
      chk("start", 8'(start_line), 8'h37);
      chk("con_ff", contrast_level, 8'hFF);
      chk("rd_left", 8'(expq.size()), 8'h00);
      tally_and_finish;
   end
endmodule // test_lcd_instruction_decoder
